/* File: asr_reg_bank.sv */
`timescale 1ns/100ps
// Contract
// - Threshold writes are taken only while the init lock is clear.
// - Both thresholds feed the writable-register check code.
// - Each threshold is an independent unsigned 8-bit value, one output LSB per step.
// - A zero threshold disables comparisons for that polarity only.
// - Both thresholds zero disables arming and its output pin.
// - Status is read-only; reading clears transient flags.
// - Internal data error flag, bit 6, sets on check-code or internal fault.
// - Persisting faults set the error flag again after a read.
// - Init flag, bit 4, holds until init completes; reads do not touch it.
// - Serial output mismatch flag, bit 3, sets on fault, clears on read.
// - Drift limit flag, bit 1, sets on limit, clears on read.
// - Reset flag, bit 0, set during init after reset, cleared on read.
// - Free-running 8-bit counter steps every 1024 oscillator periods, 128 us.
// - Drift correction value is exposed read-only.
// - OTP shadow array checked with 3-bit code, seed 111; mismatch sets error.
// - Writable check runs only once the lock is set; mismatch sets error.
module asr_reg_bank #(
   parameter int INIT_CYC = asr_pkg::INIT_CYCLES,
   parameter int OTP_W    = asr_pkg::OTP_BITS
) (
   // System clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // Link side register port
   input  wire logic               clkSpi,
   input  wire logic               lnkStrobe,
   input  wire asr_pkg::asr_req_t  lnkReq,
   output logic                    lnkReady,
   output logic [7:0]              lnkRdData,
   output logic                    lnkRdValid,
   // Device controls and events
   input  wire logic               initDoneLock,
   input  wire logic               misoMismatchEvt,
   input  wire logic               driftLimitEvt,
   input  wire logic               internalFaultEvt,
   input  wire logic [7:0]         driftCorrIn,
   input  wire logic [OTP_W-1:0]   otpShadow,
   input  wire logic [2:0]         otpCrc,
   // Arming controls and error flag output
   output logic [7:0]              armPosThreshold,
   output logic [7:0]              armNegThreshold,
   output logic                    armPosEnable,
   output logic                    armNegEnable,
   output logic                    armFunctionEnable,
   output logic                    internalDataError
);
   import asr_pkg::*;

   localparam asr_sys_t SYS_RESET = '{initBusy: 1'b1, flagReset: 1'b1, default: '0};

   asr_sys_t   s;
   asr_sys_t   next_s;
   asr_link_t  l;
   asr_link_t  next_l;
   logic       reqSync;
   logic       ackSync;
   logic       reqEvt;
   logic [7:0] statusNow;
   logic [7:0] rdClear;
   logic [2:0] wrCrc;
   logic       otpFault;
   logic       faultNow;
   logic [16:0] accSum;
   logic       oscTick;

   // ==========================================================
   // Domain crossings
   asr_sync3 #(.W(1)) u_req_sync (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     (l.reqTgl),
      .q     (reqSync)
   );

   asr_sync3 #(.W(1)) u_ack_sync (
      .clk   (clkSpi),
      .rst_n (rst_n),
      .d     (s.ackTgl),
      .q     (ackSync)
   );

   // ==========================================================
   // Link domain
   assign lnkReady = (l.reqTgl == ackSync);

   always_comb begin
      next_l         = l;
      next_l.rdValid = 1'b0;
      next_l.ackSeen = ackSync;
      if (ackSync != l.ackSeen && !l.req.write) begin
         next_l.rdData  = s.rdHold;
         next_l.rdValid = 1'b1;
      end
      if (lnkStrobe && lnkReady) begin
         next_l.req    = lnkReq;
         next_l.reqTgl = ~l.reqTgl;
      end
   end

   always_ff @(posedge clkSpi or negedge rst_n) begin
      if (!rst_n) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   assign lnkRdData  = l.rdData;
   assign lnkRdValid = l.rdValid;

   // ==========================================================
   // System domain
   always_comb begin
      next_s         = s;
      reqEvt         = (reqSync != s.reqSeen);
      next_s.reqSeen = reqSync;
      rdClear        = 8'h00;
      statusNow      = 8'h00;
      statusNow[STAT_IDE]   = s.flagIde;
      statusNow[STAT_INIT]  = s.initBusy;
      statusNow[STAT_MISO]  = s.flagMiso;
      statusNow[STAT_DRIFT] = s.flagDrift;
      statusNow[STAT_RESET] = s.flagReset;

      // Init sequence
      if (s.initBusy) begin
         if (s.initCnt == 16'(INIT_CYC - 1)) begin
            next_s.initBusy = 1'b0;
         end else begin
            next_s.initCnt = s.initCnt + 16'h0001;
         end
      end

      // Oscillator model, prescaler and counter
      accSum  = s.oscAcc + 17'(CLK_PERIOD_PS);
      oscTick = (accSum >= 17'(OSC_PERIOD_PS));
      next_s.oscAcc = oscTick ? accSum - 17'(OSC_PERIOD_PS) : accSum;
      if (oscTick) begin
         next_s.prescale = s.prescale + 10'h001;
         if (s.prescale == 10'h3ff) begin
            next_s.oscCount = s.oscCount + 8'h01;
         end
      end

      next_s.corr = driftCorrIn;

      // Register access
      if (reqEvt) begin
         next_s.ackTgl = ~s.ackTgl;
         next_s.rdHold = 8'h00;
         if (l.req.write) begin
            unique case (l.req.addr)
               ADDR_POS_THR: begin
                  if (!initDoneLock) begin
                     next_s.thrPos = l.req.data;
                  end
               end
               ADDR_NEG_THR: begin
                  if (!initDoneLock) begin
                     next_s.thrNeg = l.req.data;
                  end
               end
               ADDR_RSVD_A: begin
                  next_s.rsvdA = l.req.data;
               end
               ADDR_RSVD_B: begin
                  next_s.rsvdB = l.req.data;
               end
               default: begin
               end
            endcase
         end else begin
            unique case (l.req.addr)
               ADDR_POS_THR: begin
                  next_s.rdHold = s.thrPos;
               end
               ADDR_NEG_THR: begin
                  next_s.rdHold = s.thrNeg;
               end
               ADDR_STATUS: begin
                  next_s.rdHold = statusNow;
                  rdClear       = statusNow;
               end
               ADDR_OSC_COUNT: begin
                  next_s.rdHold = s.oscCount;
               end
               ADDR_DRIFT_CORR: begin
                  next_s.rdHold = s.corr;
               end
               ADDR_RSVD_A: begin
                  next_s.rdHold = s.rsvdA;
               end
               ADDR_RSVD_B: begin
                  next_s.rdHold = s.rsvdB;
               end
               default: begin
               end
            endcase
         end
      end

      // Writable and OTP check codes
      wrCrc = asr_crc3({16'h0000, s.thrPos, s.thrNeg}, 16);
      if (initDoneLock && !s.wrArmed) begin
         next_s.wrArmed  = 1'b1;
         next_s.wrGolden = wrCrc;
      end
      if (s.wrArmed && wrCrc != s.wrGolden) begin
         next_s.wrFault = 1'b1;
      end
      otpFault = (asr_crc3(32'(otpShadow), OTP_W) != otpCrc);
      faultNow = otpFault | s.wrFault | internalFaultEvt;

      // Flags, a new set wins over the read clear
      next_s.flagIde   = (s.flagIde & ~rdClear[STAT_IDE]) | faultNow;
      next_s.flagMiso  = (s.flagMiso & ~rdClear[STAT_MISO]) | misoMismatchEvt;
      next_s.flagDrift = (s.flagDrift & ~rdClear[STAT_DRIFT]) | driftLimitEvt;
      next_s.flagReset = (s.flagReset & ~rdClear[STAT_RESET]) | s.initBusy;

      // Arming enables
      next_s.armPosEn = (next_s.thrPos != 8'h00);
      next_s.armNegEn = (next_s.thrNeg != 8'h00);
      next_s.armEn    = next_s.armPosEn | next_s.armNegEn;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= SYS_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign armPosThreshold   = s.thrPos;
   assign armNegThreshold   = s.thrNeg;
   assign armPosEnable      = s.armPosEn;
   assign armNegEnable      = s.armNegEn;
   assign armFunctionEnable = s.armEn;
   assign internalDataError = s.flagIde;

   // ==========================================================
   // Checks
   a_lock_blocks_write: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && l.req.write && l.req.addr == ADDR_POS_THR && initDoneLock |=> $stable(s.thrPos))
      else $error("positive threshold changed while locked");

   a_thr_write_taken: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && l.req.write && l.req.addr == ADDR_NEG_THR && !initDoneLock
      |=> armNegThreshold == $past(l.req.data))
      else $error("negative threshold write not taken");

   a_one_side_off: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s.thrPos != 8'h00 && s.thrNeg == 8'h00 |-> armPosEnable && !armNegEnable && armFunctionEnable)
      else $error("single polarity disable wrong");

   a_both_zero_off: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s.thrPos == 8'h00 && s.thrNeg == 8'h00 |-> !armFunctionEnable)
      else $error("arming left enabled with both thresholds zero");

   a_miso_read_clear: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && !l.req.write && l.req.addr == ADDR_STATUS && s.flagMiso && !misoMismatchEvt
      |=> !s.flagMiso)
      else $error("mismatch flag not cleared by status read");

   a_ide_reassert: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s.wrFault |=> s.flagIde [*2])
      else $error("error flag not held while fault persists");

   a_init_length: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $fell(s.initBusy) |-> $past(s.initCnt) == 16'(INIT_CYC - 1))
      else $error("init flag dropped at wrong count");

   a_miso_set: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      misoMismatchEvt |=> s.flagMiso)
      else $error("mismatch event lost");

   a_drift_set: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      driftLimitEvt |=> s.flagDrift)
      else $error("drift event lost");

   a_reset_flag: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s.initBusy |=> s.flagReset)
      else $error("reset flag clear during init");

   a_count_step: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      s.oscCount != $past(s.oscCount) |-> $past(s.prescale) == 10'h3ff && s.prescale == 10'h000)
      else $error("counter stepped off prescaler wrap");

   a_corr_follow: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> s.corr == $past(driftCorrIn))
      else $error("correction value not tracked");

   a_otp_fault: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      otpFault |=> internalDataError)
      else $error("otp mismatch did not set error flag");

   a_wr_check_gate: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      !s.wrArmed |-> !s.wrFault)
      else $error("writable check ran before lock");

   a_read_snapshot: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && !l.req.write && l.req.addr == ADDR_STATUS |=> s.rdHold == $past(statusNow))
      else $error("status read value not captured");

   a_link_hold: assert property (
      @(posedge clkSpi) disable iff (!rst_n)
      !lnkReady |=> $stable(l.req))
      else $error("request changed while in flight");

   a_pos_write_taken: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && l.req.write && l.req.addr == ADDR_POS_THR && !initDoneLock
      |=> armPosThreshold == $past(l.req.data))
      else $error("positive threshold write not taken");

   a_neg_lock_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && l.req.write && l.req.addr == ADDR_NEG_THR && initDoneLock |=> $stable(s.thrNeg))
      else $error("negative threshold changed while locked");

   a_init_read_keep: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      reqEvt && !l.req.write && l.req.addr == ADDR_STATUS && s.initBusy && s.initCnt != 16'(INIT_CYC - 1)
      |=> s.initBusy)
      else $error("status read touched the init flag");

   a_rd_valid_pulse: assert property (
      @(posedge clkSpi) disable iff (!rst_n)
      lnkRdValid |=> !lnkRdValid)
      else $error("read valid held longer than one cycle");

endmodule : asr_reg_bank

/* File: asr_pkg.sv */
package asr_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_POS_THR    = 8'h10;
   localparam logic [7:0] ADDR_NEG_THR    = 8'h12;
   localparam logic [7:0] ADDR_STATUS     = 8'h14;
   localparam logic [7:0] ADDR_OSC_COUNT  = 8'h15;
   localparam logic [7:0] ADDR_DRIFT_CORR = 8'h16;
   localparam logic [7:0] ADDR_RSVD_A     = 8'h1c;
   localparam logic [7:0] ADDR_RSVD_B     = 8'h1d;

   // ==========================================================
   // Status bit positions
   localparam int STAT_IDE   = 6;
   localparam int STAT_INIT  = 4;
   localparam int STAT_MISO  = 3;
   localparam int STAT_DRIFT = 1;
   localparam int STAT_RESET = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] THR_RESET   = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CORR_RESET  = 8'h00;
   localparam logic [7:0] RSVD_RESET  = 8'h00;

   // ==========================================================
   // Check code
   localparam logic [2:0] CRC_POLY = 3'h3;
   localparam logic [2:0] CRC_SEED = 3'h7;
   localparam int         OTP_BITS = 32;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int COUNT_STEP_US = 128;
   localparam int PRESCALE_DIV  = 1024;
   localparam int CLK_PERIOD_PS = CLK_PERIOD_NS * 1000;
   localparam int OSC_PERIOD_PS = COUNT_STEP_US * 1000000 / PRESCALE_DIV;
   localparam int INIT_CYCLES   = 16;

   // ==========================================================
   // Types
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } asr_req_t;

   typedef struct packed {
      asr_req_t   req;
      logic       reqTgl;
      logic       ackSeen;
      logic [7:0] rdData;
      logic       rdValid;
   } asr_link_t;

   typedef struct packed {
      logic [7:0]  thrPos;
      logic [7:0]  thrNeg;
      logic        armPosEn;
      logic        armNegEn;
      logic        armEn;
      logic [7:0]  rsvdA;
      logic [7:0]  rsvdB;
      logic        flagIde;
      logic        flagMiso;
      logic        flagDrift;
      logic        flagReset;
      logic        initBusy;
      logic [15:0] initCnt;
      logic [2:0]  wrGolden;
      logic        wrArmed;
      logic        wrFault;
      logic [16:0] oscAcc;
      logic [9:0]  prescale;
      logic [7:0]  oscCount;
      logic [7:0]  corr;
      logic [7:0]  rdHold;
      logic        ackTgl;
      logic        reqSeen;
   } asr_sys_t;

   // ==========================================================
   // Serial 3-bit check over the low nbits of d, msb first
   function automatic logic [2:0] asr_crc3(input logic [31:0] d, input int nbits);
      logic [2:0] c;
      logic       fb;
      c = CRC_SEED;
      for (int i = 31; i >= 0; i--) begin
         if (i < nbits) begin
            fb = c[2] ^ d[i];
            c  = {c[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
         end
      end
      return c;
   endfunction : asr_crc3

endpackage : asr_pkg

/* File: asr_sync3.sv */
`timescale 1ns/100ps
module asr_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import asr_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } asr_sync_state_t;

   asr_sync_state_t s;
   asr_sync_state_t next_s;

   // ==========================================================
   // Three stages, accept when second and third agree
   always_comb begin
      next_s    = s;
      next_s.s1 = d;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      if (s.s2 == s.s3) begin
         next_s.q = s.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;

endmodule : asr_sync3

/* File: asr_spi_master.sv */
`timescale 1ns/100ps
module asr_spi_master (
   // Clock control
   input  wire logic              clkHold,
   output logic                   clkSpi,
   // Request side
   output logic                   lnkStrobe,
   output asr_pkg::asr_req_t      lnkReq,
   // Answer side
   input  wire logic              lnkReady,
   input  wire logic [7:0]        lnkRdData,
   input  wire logic              lnkRdValid
);
   import asr_pkg::*;

   logic clkRun;

   // ==========================================================
   // Link clock, runs during transfers and while clkHold is set, still otherwise
   initial begin
      clkSpi    = 1'b0;
      clkRun    = 1'b0;
      lnkStrobe = 1'b0;
      lnkReq    = '0;
      #7;
      forever begin
         #24;
         if (clkRun || clkHold || clkSpi) clkSpi = ~clkSpi;
      end
   end

   // ==========================================================
   // One register transfer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] dd;
      int         n;
      dd = d;
      q  = 8'hxx;
      n  = 0;
      if (a == ADDR_RSVD_A || a == ADDR_RSVD_B) dd = 8'h00;
      clkRun = 1'b1;
      @(posedge clkSpi);
      lnkStrobe <= 1'b1;
      lnkReq    <= '{write: wr, addr: a, data: dd};
      @(posedge clkSpi);
      while (lnkReady !== 1'b1 && n < 40) begin
         @(posedge clkSpi);
         n++;
      end
      lnkStrobe <= 1'b0;
      lnkReq    <= asr_req_t'(~lnkReq);
      n = 0;
      do begin
         @(posedge clkSpi);
         n++;
      end while (!(wr ? lnkReady === 1'b1 : lnkRdValid === 1'b1) && n < 40);
      if (!wr && lnkRdValid === 1'b1) q = (a == ADDR_STATUS) ? (lnkRdData & 8'h5f) : lnkRdData;
      repeat (2) @(posedge clkSpi);
      clkRun = 1'b0;
   endtask : xfer

endmodule : asr_spi_master

/* File: arming_status_register_bank_tb.sv */
`timescale 1ns/100ps
module arming_status_register_bank_tb;
   import asr_pkg::*;

   localparam int INIT_T = 200;

   logic             clk_sys;
   logic             rst_n;
   logic             clkHold;
   logic             initDoneLock;
   logic             misoEvt;
   logic             driftEvt;
   logic             faultEvt;
   logic [7:0]       corrIn;
   logic [31:0]      otp;
   logic [2:0]       otpCode;
   logic             clkSpi;
   logic             lnkStrobe;
   asr_req_t         lnkReq;
   logic             lnkReady;
   logic [7:0]       lnkRdData;
   logic             lnkRdValid;
   logic [7:0]       armPos;
   logic [7:0]       armNeg;
   logic             armPosEn;
   logic             armNegEn;
   logic             armFnEn;
   logic             ideOut;
   int               failCount;
   int               cmpCount;
   int               cycles;

   // ==========================================================
   // Instances
   asr_reg_bank #(.INIT_CYC(INIT_T)) u_asr_reg_bank (
      .clk_sys(clk_sys), .rst_n(rst_n), .clkSpi(clkSpi), .lnkStrobe(lnkStrobe), .lnkReq(lnkReq),
      .lnkReady(lnkReady), .lnkRdData(lnkRdData), .lnkRdValid(lnkRdValid), .initDoneLock(initDoneLock),
      .misoMismatchEvt(misoEvt), .driftLimitEvt(driftEvt), .internalFaultEvt(faultEvt),
      .driftCorrIn(corrIn), .otpShadow(otp), .otpCrc(otpCode), .armPosThreshold(armPos),
      .armNegThreshold(armNeg), .armPosEnable(armPosEn), .armNegEnable(armNegEn),
      .armFunctionEnable(armFnEn), .internalDataError(ideOut));

   asr_spi_master u_asr_spi_master (
      .clkHold(clkHold), .clkSpi(clkSpi), .lnkStrobe(lnkStrobe), .lnkReq(lnkReq),
      .lnkReady(lnkReady), .lnkRdData(lnkRdData), .lnkRdValid(lnkRdValid));

   // ==========================================================
   // Helpers
   function automatic logic [2:0] crcRef(input logic [31:0] v);
      logic [2:0] c;
      c = 3'h7;
      for (int i = 31; i >= 0; i--) c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? 3'h3 : 3'h0);
      return c;
   endfunction : crcRef

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      u_asr_spi_master.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_asr_spi_master.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic pulse(input int k);
      @(posedge clk_sys);
      if (k == 0) misoEvt <= 1'b1;
      if (k == 1) driftEvt <= 1'b1;
      if (k == 2) faultEvt <= 1'b1;
      @(posedge clk_sys);
      misoEvt  <= 1'b0;
      driftEvt <= 1'b0;
      faultEvt <= 1'b0;
   endtask : pulse

   // ==========================================================
   // Scenarios
   task automatic tInit();
      rd(ADDR_STATUS, 8'h11);
      rd(ADDR_STATUS, 8'h11);
      repeat (INIT_T) @(posedge clk_sys);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS, 8'h00);
      $display("init test done");
   endtask : tInit

   task automatic tThresh();
      logic [7:0] tp [4] = '{8'h64, 8'h00, 8'h00, 8'hff};
      logic [7:0] tn [4] = '{8'h00, 8'h32, 8'h00, 8'h01};
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_POS_THR, tp[i]);
         wr(ADDR_NEG_THR, tn[i]);
         rd(ADDR_POS_THR, tp[i]);
         rd(ADDR_NEG_THR, tn[i]);
         chk(armNeg, tn[i]);
         chk(armPos, tp[i]);
         chk({5'h0, armPosEn, armNegEn, armFnEn}, {5'h0, tp[i] != 8'h00, tn[i] != 8'h00, (tp[i] | tn[i]) != 8'h00});
      end
      wr(ADDR_RSVD_A, 8'h00);
      rd(ADDR_RSVD_A, 8'h00);
      wr(ADDR_RSVD_B, 8'h00);
      rd(ADDR_RSVD_B, 8'h00);
      wr(ADDR_DRIFT_CORR, 8'h5a);
      rd(ADDR_DRIFT_CORR, 8'h3c);
      wr(ADDR_STATUS, 8'hff);
      rd(ADDR_STATUS, 8'h00);
      rd(8'h20, 8'h00);
      $display("threshold test done");
   endtask : tThresh

   task automatic tEvents();
      pulse(0);
      pulse(1);
      rd(ADDR_STATUS, 8'h0a);
      rd(ADDR_STATUS, 8'h00);
      $display("event test done");
   endtask : tEvents

   task automatic tFault();
      pulse(2);
      rd(ADDR_STATUS, 8'h40);
      rd(ADDR_STATUS, 8'h00);
      @(posedge clk_sys);
      otpCode <= ~crcRef(otp);
      rd(ADDR_STATUS, 8'h40);
      rd(ADDR_STATUS, 8'h40);
      chk({7'h0, ideOut}, 8'h01);
      @(posedge clk_sys);
      otpCode <= crcRef(otp);
      rd(ADDR_STATUS, 8'h40);
      rd(ADDR_STATUS, 8'h00);
      $display("fault test done");
   endtask : tFault

   task automatic tLock();
      @(posedge clk_sys);
      initDoneLock <= 1'b1;
      wr(ADDR_POS_THR, 8'h11);
      wr(ADDR_NEG_THR, 8'h22);
      rd(ADDR_POS_THR, 8'hff);
      rd(ADDR_NEG_THR, 8'h01);
      rd(ADDR_STATUS, 8'h00);
      $display("lock test done");
   endtask : tLock

   task automatic tReset();
      @(posedge clk_sys);
      rst_n        <= 1'b0;
      clkHold      <= 1'b1;
      initDoneLock <= 1'b0;
      otpCode      <= ~crcRef(otp);
      repeat (12) @(posedge clk_sys);
      rst_n   <= 1'b1;
      clkHold <= 1'b0;
      chk(armPos | armNeg, 8'h00);
      rd(ADDR_STATUS, 8'h51);
      @(posedge clk_sys);
      otpCode <= crcRef(otp);
      repeat (INIT_T) @(posedge clk_sys);
      rd(ADDR_STATUS, 8'h41);
      rd(ADDR_STATUS, 8'h00);
      $display("reset test done");
   endtask : tReset

   task automatic tCount();
      logic [7:0] c0;
      logic [7:0] c1;
      u_asr_spi_master.xfer(1'b0, ADDR_OSC_COUNT, 8'h00, c0);
      repeat (25600) @(posedge clk_sys);
      u_asr_spi_master.xfer(1'b0, ADDR_OSC_COUNT, 8'h00, c1);
      chk(c1 - c0, 8'h02);
      $display("count test done");
   endtask : tCount

   task automatic giveVerdict();
      $display("compares %0d, mismatches %0d", cmpCount, failCount);
      if (failCount == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : giveVerdict

   // ==========================================================
   // Clock, timeout and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         failCount++;
         giveVerdict();
      end
   end

   initial begin
      failCount    = 0;
      cmpCount     = 0;
      cycles       = 0;
      rst_n        = 1'b0;
      clkHold      = 1'b1;
      initDoneLock = 1'b0;
      misoEvt      = 1'b0;
      driftEvt     = 1'b0;
      faultEvt     = 1'b0;
      corrIn       = 8'h3c;
      otp          = 32'h5a3c96e1;
      otpCode      = crcRef(32'h5a3c96e1);
      repeat (10) @(posedge clk_sys);
      chk(armPos, 8'h00);
      chk({5'h0, lnkReady, lnkRdValid, ideOut}, 8'h04);
      repeat (2) @(posedge clk_sys);
      rst_n   <= 1'b1;
      clkHold <= 1'b0;
      tInit();
      tThresh();
      tEvents();
      tFault();
      tLock();
      tReset();
      tCount();
      giveVerdict();
   end

endmodule : arming_status_register_bank_tb
